// [ivpm_ctrl.sv]
// Interrupt vector, reset cause and power mode controller
//
// Behaviour
// - Vectors and start address lie in 0xffc0..0xffff.
// - Each vector word is a 16-bit handler address loaded into the PC.
// - Erased reset vector 0xffff sends the device to sleep level four.
// - Five reset causes share the reset vector at top priority.
// - External NMI, oscillator fault, flash access share vector 0xfffc.
// - Port two, two flags, share vector 0xffe6 at level 19.
// - Port one, eight flags, share vector 0xffe4 at level 18.
// - Any interrupt wakes from sleep; return restores prior sleep level.
// - Run mode enables CPU, main, sub-main and auxiliary clocks.
// - Level zero halts CPU and main clock; aux and sub-main run.
// - Level one also drops oscillator dc generator if unused in run.
// - Level two gates main and sub-main; aux and dc generator on.
// - Level three keeps only the auxiliary clock and the crystal running.
// - Level four stops all clocks, dc generator and crystal.
// - NMI sources blocked by own enable, not the global enable.
// - Fetch from peripheral or unused range forces reset.
// - Vectors 0xffc0..0xffde are never used by any source.
`timescale 1ns/10ps
`default_nettype none

module ivpm_ctrl
  import ivpm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Event pulses from peripherals and pins (asynchronous)
  input  wire logic [4:0]          rst_events,
  input  wire logic [2:0]          nmi_events,
  input  wire logic [N_MASK-1:0]   mask_req,
  // CPU side
  input  wire logic [15:0]         fetch_addr,
  input  wire logic                fetch_valid,
  input  wire logic                reti,
  output var  ivpm_pkg::ivpm_fetch_t vec_fetch,
  input  wire logic [15:0]         vec_data,
  input  wire logic                vec_data_valid,
  output var  logic [15:0]         pc_load_value,
  output var  logic                pc_load,
  output var  logic                sys_reset,
  output var  ivpm_pkg::ivpm_clk_t clk_gate
);
  import ivpm_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    ivpm_state_t  st;
    logic [4:0]   rst_s1, rst_s2, rst_s3;
    logic [2:0]   nmi_s1, nmi_s2, nmi_s3;
    logic [N_MASK-1:0] msk_s1, msk_s2;
    logic         gie;
    ivpm_sleep_t  sleep;
    ivpm_sleep_t  saved_sleep;
    logic         saved_gie;
    logic         dco_used;
    logic [2:0]   nmi_en;
    logic [N_MASK-1:0] mask_en;
    logic [4:0]   rst_flg;
    logic [2:0]   nmi_flg;
    logic         is_reset_vec;
    logic         aw_got, w_got;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid, arready, rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp, bresp;
    ivpm_fetch_t  fetch;
    logic [15:0]  pc_val;
    logic         pc_ld;
    logic         sreset;
    ivpm_clk_t    clk;
  } ivpm_regs_t;

  ivpm_regs_t q, d;

  // Vector choice from pending requests
  logic [15:0]       best_vec;
  logic              any_int;
  logic              nmi_pend;
  logic [N_MASK-1:0] mpend;
  logic              rst_pend;
  logic              bad_fetch;
  logic              wr_fire;
  logic [31:0]       rd_word;
  logic              rd_ok;
  ivpm_sleep_t       eff_sleep;

  // ---------------------------------------------------------------------------
  // Priority encode
  // ---------------------------------------------------------------------------
  // Higher address first; vectors below 0xffe0 are never produced
  always_comb begin
    mpend    = q.msk_s2 & q.mask_en;
    nmi_pend = |(q.nmi_flg & q.nmi_en);
    rst_pend = |(q.rst_s2 & ~q.rst_s3);
    best_vec = VEC_RESET;
    any_int  = 1'b1;
    if (nmi_pend) begin
      best_vec = VEC_NMI;
    end else if (q.gie && mpend[0]) begin
      best_vec = VEC_ITIMER;
    end else if (q.gie && mpend[1]) begin
      best_vec = VEC_TCH0;
    end else if (q.gie && mpend[2]) begin
      best_vec = VEC_TCH1;
    end else if (q.gie && mpend[3]) begin
      best_vec = VEC_ADC;
    end else if (q.gie && mpend[4]) begin
      best_vec = VEC_SERIAL;
    end else if (q.gie && |mpend[6:5]) begin
      best_vec = VEC_PORT_TWO;
    end else if (q.gie && |mpend[14:7]) begin
      best_vec = VEC_PORT_ONE;
    end else begin
      any_int  = 1'b0;
    end
  end

  // Fetch outside peripheral-free, implemented memory forces reset
  always_comb begin
    bad_fetch = fetch_valid &&
      !((fetch_addr >= RAM_LOW && fetch_addr <= RAM_HIGH) ||
        (fetch_addr >= INFO_LOW && fetch_addr <= INFO_HIGH) ||
        (fetch_addr >= CODE_LOW));
  end

  // ---------------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      REG_MODE:    rd_word = {23'h0, q.dco_used, 1'b0, q.sleep, 3'h0, q.gie};
      REG_NMI_EN:  rd_word = {29'h0, q.nmi_en};
      REG_MASK_EN: rd_word = {17'h0, q.mask_en};
      REG_RST_FLG: rd_word = {27'h0, q.rst_flg};
      REG_NMI_FLG: rd_word = {29'h0, q.nmi_flg};
      REG_STATUS:  rd_word = {q.fetch.addr, 11'h0, q.st};
      REG_CLK:     rd_word = {26'h0, q.clk};
      default:     rd_ok   = 1'b0;
    endcase
  end
  // Status word holds the last requested vector address in the top half

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    // Two-stage synchronisers; an edge stage for reset and NMI events only
    d.rst_s1 = rst_events;
    d.rst_s2 = q.rst_s1;
    d.rst_s3 = q.rst_s2;
    d.nmi_s1 = nmi_events;
    d.nmi_s2 = q.nmi_s1;
    d.nmi_s3 = q.nmi_s2;
    d.msk_s1 = mask_req;
    d.msk_s2 = q.msk_s1;
    d.pc_ld  = 1'b0;
    d.sreset = 1'b0;
    d.fetch.req = 1'b0;

    // AXI4-Lite write: address and data in either order
    wr_fire = 1'b0;
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      wr_fire  = 1'b1;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Hardware sets the NMI flags; a set wins over a clear
    if (wr_fire && q.w_strb[0]) begin
      case (q.aw_addr)
        REG_MODE: begin
          d.gie      = q.w_data[MODE_GIE_BIT];
          d.sleep    = ivpm_sleep_t'(q.w_data[MODE_SLP_LSB +: 3]);
        end
        REG_NMI_EN:  d.nmi_en  = q.w_data[2:0];
        REG_MASK_EN: d.mask_en[7:0] = q.w_data[7:0];
        REG_RST_FLG: d.rst_flg = q.rst_flg & ~q.w_data[4:0];
        REG_NMI_FLG: d.nmi_flg = q.nmi_flg & ~q.w_data[2:0];
        default: d.bresp = 2'b10;
      endcase
    end
    // Byte one carries the oscillator-use bit and the upper mask enables
    if (wr_fire && q.w_strb[1]) begin
      if (q.aw_addr == REG_MODE) d.dco_used = q.w_data[MODE_DCO_BIT];
      if (q.aw_addr == REG_MASK_EN) d.mask_en[14:8] = q.w_data[14:8];
    end
    d.nmi_flg = d.nmi_flg | (q.nmi_s2 & ~q.nmi_s3);
    d.rst_flg = d.rst_flg | (q.rst_s2 & ~q.rst_s3);

    // AXI4-Lite read
    d.arready = 1'b0;
    if (s_axi_arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
      d.rvalid  = 1'b1;
      d.rdata   = rd_word;
      d.rresp   = rd_ok ? 2'b00 : 2'b10;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Controller sequence
    case (q.st)
      ST_BOOT: begin
        d.fetch = '{req: 1'b1, addr: VEC_RESET};
        d.is_reset_vec = 1'b1;
        d.st = ST_CHECK;
      end
      ST_CHECK: begin
        d.fetch.req = 1'b1;
        if (vec_data_valid) begin
          d.fetch.req = 1'b0;
          if (vec_data == ERASED_WORD) begin
            d.sleep = SLEEP_LEVEL_FOUR;
            d.gie   = 1'b0;
          end else begin
            d.pc_val = vec_data;
            d.pc_ld  = 1'b1;
          end
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_pend || bad_fetch) begin
          d.sreset = 1'b1;
          if (bad_fetch) d.rst_flg[RF_PCOOR] = 1'b1;
          d.sleep  = FULL_RUN_MODE;
          d.gie    = 1'b0;
          d.st     = ST_BOOT;
        end else if (any_int) begin
          d.saved_sleep = q.sleep;
          d.saved_gie   = q.gie;
          d.sleep       = FULL_RUN_MODE;
          d.gie         = 1'b0;
          d.fetch       = '{req: 1'b1, addr: best_vec};
          d.st          = ST_VEC;
        end
      end
      ST_VEC: begin
        d.fetch.req = 1'b1;
        if (vec_data_valid) begin
          d.fetch.req = 1'b0;
          d.pc_val    = vec_data;
          d.pc_ld     = 1'b1;
          d.st        = ST_ISR;
        end
      end
      ST_ISR: begin
        if (rst_pend || bad_fetch) begin
          d.sreset = 1'b1;
          if (bad_fetch) d.rst_flg[RF_PCOOR] = 1'b1;
          d.sleep  = FULL_RUN_MODE;
          d.gie    = 1'b0;
          d.st     = ST_BOOT;
        end else if (reti) begin
          d.sleep = q.saved_sleep;
          d.gie   = q.saved_gie;
          d.st    = ST_RUN;
        end
      end
      default: d.st = ST_BOOT;
    endcase

    // Clock gating from the effective sleep level
    eff_sleep = d.sleep;
    d.clk = '{cpu_run: 1'b1, main_clock: 1'b1, sub_main_clock: 1'b1,
              aux_clock: 1'b1, digital_oscillator: 1'b1,
              crystal_run: 1'b1};
    case (eff_sleep)
      SLEEP_LEVEL_ZERO: begin
        d.clk.cpu_run    = 1'b0;
        d.clk.main_clock = 1'b0;
      end
      SLEEP_LEVEL_ONE: begin
        d.clk.cpu_run            = 1'b0;
        d.clk.main_clock         = 1'b0;
        d.clk.digital_oscillator = d.dco_used;
      end
      SLEEP_LEVEL_TWO: begin
        d.clk.cpu_run        = 1'b0;
        d.clk.main_clock     = 1'b0;
        d.clk.sub_main_clock = 1'b0;
      end
      SLEEP_LEVEL_THREE: begin
        d.clk.cpu_run            = 1'b0;
        d.clk.main_clock         = 1'b0;
        d.clk.sub_main_clock     = 1'b0;
        d.clk.digital_oscillator = 1'b0;
      end
      SLEEP_LEVEL_FOUR: begin
        d.clk = '0;
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.st       <= ST_BOOT;
      q.sleep    <= FULL_RUN_MODE;
      q.saved_sleep <= FULL_RUN_MODE;
      q.nmi_en   <= NMI_EN_RST;
      q.mask_en  <= MASK_EN_RST;
      q.rst_flg  <= RST_FLG_RST;
      q.dco_used <= 1'b1;
      q.clk      <= '1;
    end else begin
      q <= d;
    end
  end

  // Outputs from flip-flops; awready and wready decoded from flop state
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign vec_fetch     = q.fetch;
  assign pc_load_value = q.pc_val;
  assign pc_load       = q.pc_ld;
  assign sys_reset     = q.sreset;
  assign clk_gate      = q.clk;

endmodule : ivpm_ctrl

`default_nettype wire

// [ivpm_pkg.sv]
// Package: constants and carriers for the interrupt vector and power mode block
package ivpm_pkg;

  // ---------------------------------------------------------------------------
  // Vector table
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_TOP_ADDR   = 16'hffff;
  localparam logic [15:0] VEC_LOW_ADDR   = 16'hffc0;
  localparam logic [15:0] VEC_UNUSED_TOP = 16'hffde;
  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [15:0] VEC_NMI        = 16'hfffc;
  localparam logic [15:0] VEC_ITIMER     = 16'hfff4;
  localparam logic [15:0] VEC_TCH0       = 16'hfff2;
  localparam logic [15:0] VEC_TCH1       = 16'hfff0;
  localparam logic [15:0] VEC_ADC        = 16'hffea;
  localparam logic [15:0] VEC_SERIAL     = 16'hffe8;
  localparam logic [15:0] VEC_PORT_TWO   = 16'hffe6;
  localparam logic [15:0] VEC_PORT_ONE   = 16'hffe4;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;

  // Fetch ranges; fetches outside RAM, info and code force a reset
  localparam logic [15:0] PERIPH_LOW     = 16'h0000;
  localparam logic [15:0] PERIPH_HIGH    = 16'h01ff;
  localparam logic [15:0] RAM_LOW        = 16'h0200;
  localparam logic [15:0] RAM_HIGH       = 16'h027f;
  localparam logic [15:0] INFO_LOW       = 16'h1000;
  localparam logic [15:0] INFO_HIGH      = 16'h10ff;
  localparam logic [15:0] CODE_LOW       = 16'hf800;

  // ---------------------------------------------------------------------------
  // Register map (AXI4-Lite byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_MODE     = 8'h00;  // Sleep bits, global enable
  localparam logic [7:0] REG_NMI_EN   = 8'h04;  // Per-source NMI enables
  localparam logic [7:0] REG_MASK_EN  = 8'h08;  // Maskable source enables
  localparam logic [7:0] REG_RST_FLG  = 8'h0c;  // Reset cause flags
  localparam logic [7:0] REG_NMI_FLG  = 8'h10;  // NMI source flags
  localparam logic [7:0] REG_STATUS   = 8'h14;  // Current state and vector
  localparam logic [7:0] REG_CLK      = 8'h18;  // Clock gate outputs

  // Field positions of REG_MODE
  localparam int MODE_GIE_BIT = 0;
  localparam int MODE_SLP_LSB = 4;
  localparam int MODE_DCO_BIT = 8;   // Oscillator used in run mode

  // Reset flags, bit positions
  localparam int RF_PWR   = 0;
  localparam int RF_EXT   = 1;
  localparam int RF_WDOG  = 2;
  localparam int RF_KEY   = 3;
  localparam int RF_PCOOR = 4;

  // NMI flags, bit positions
  localparam int NF_EXT  = 0;
  localparam int NF_OSC  = 1;
  localparam int NF_ACCV = 2;

  // Maskable request lines: 0 itimer, 1 tch0, 2 tch1, 3 adc, 4 serial,
  // 5..6 port two, 7..14 port one
  localparam int N_MASK = 15;
  localparam logic [2:0] NMI_EN_RST = 3'h0;
  localparam logic [14:0] MASK_EN_RST = 15'h0000;
  localparam logic [4:0] RST_FLG_RST = 5'h01;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FULL_RUN_MODE     = 3'h0,
    SLEEP_LEVEL_ZERO  = 3'h1,
    SLEEP_LEVEL_ONE   = 3'h2,
    SLEEP_LEVEL_TWO   = 3'h3,
    SLEEP_LEVEL_THREE = 3'h4,
    SLEEP_LEVEL_FOUR  = 3'h5
  } ivpm_sleep_t;

  typedef enum logic [4:0] {
    ST_BOOT  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_VEC   = 5'b01000,
    ST_ISR   = 5'b10000
  } ivpm_state_t;

  // Clock gate bundle
  typedef struct packed {
    logic cpu_run;
    logic main_clock;
    logic sub_main_clock;
    logic aux_clock;
    logic digital_oscillator;
    logic crystal_run;
  } ivpm_clk_t;

  // Vector fetch request to the memory
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } ivpm_fetch_t;

endpackage : ivpm_pkg

// [ivpm_ctrl_monitor.sv]
// Checker for vector fetch, reset and clock gate behaviour
`timescale 1ns/10ps
`default_nettype none
module ivpm_ctrl_monitor
  import ivpm_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [4:0]            rst_events,
  input wire logic [15:0]           fetch_addr,
  input wire logic                  fetch_valid,
  input wire ivpm_pkg::ivpm_fetch_t vec_fetch,
  input wire logic [15:0]           vec_data,
  input wire logic                  vec_data_valid,
  input wire logic [15:0]           pc_load_value,
  input wire logic                  pc_load,
  input wire logic                  sys_reset,
  input wire ivpm_pkg::ivpm_clk_t   clk_gate
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Vector word answered, and the erased reset word case
  sequence s_word;
    vec_fetch.req && vec_data_valid;
  endsequence
  sequence s_erased;
    s_word ##0 (vec_fetch.addr == VEC_RESET && vec_data == ERASED_WORD);
  endsequence
  a_vec_region:
    assert property (vec_fetch.req |-> vec_fetch.addr >= VEC_LOW_ADDR)
    else $error("vector fetch below table");
  a_vec_unused:
    assert property (vec_fetch.req |-> vec_fetch.addr > VEC_UNUSED_TOP)
    else $error("unused vector fetched");
  a_pc_from_word:
    assert property (s_word ##0 vec_data != ERASED_WORD
      |=> pc_load && pc_load_value == $past(vec_data))
    else $error("pc not loaded from vector word");
  a_req_holds:
    assert property (vec_fetch.req && !vec_data_valid
      |=> vec_fetch.req && $stable(vec_fetch.addr))
    else $error("vector request dropped");
  a_erased_deep:
    assert property (s_erased |=> ##[0:8] clk_gate == 6'h00)
    else $error("erased vector did not stop clocks");
  a_cause_reset:
    assert property ($rose(|rst_events) |-> ##[1:8] sys_reset)
    else $error("reset cause gave no reset");
  a_reset_fetch:
    assert property ($rose(sys_reset)
      |-> ##[0:6] (vec_fetch.req && vec_fetch.addr == VEC_RESET))
    else $error("reset vector not fetched");
  a_bad_fetch:
    assert property (fetch_valid && fetch_addr <= PERIPH_HIGH
      |-> ##[1:6] sys_reset)
    else $error("peripheral fetch gave no reset");
  a_run_clocks:
    assert property (clk_gate.cpu_run |-> clk_gate.main_clock
      && clk_gate.sub_main_clock && clk_gate.aux_clock)
    else $error("run mode clock off");
  a_main_gated:
    assert property (clk_gate.main_clock |-> clk_gate.cpu_run)
    else $error("main clock without cpu");
  a_sub_needs_aux:
    assert property (clk_gate.sub_main_clock |-> clk_gate.aux_clock)
    else $error("sub-main without aux");
  a_aux_off_all:
    assert property (!clk_gate.aux_clock |-> clk_gate == 6'h00)
    else $error("aux off but others on");
endmodule // ivpm_ctrl_monitor

bind ivpm_ctrl ivpm_ctrl_monitor u_ivpm_ctrl_monitor (
  .aclk, .aresetn, .rst_events, .fetch_addr, .fetch_valid, .vec_fetch,
  .vec_data, .vec_data_valid, .pc_load_value, .pc_load, .sys_reset,
  .clk_gate
);
`default_nettype wire

// [ivpm_vec_mem.sv]
// Vector word memory that answers the controller's fetches
`timescale 1ns/10ps
`default_nettype none
module ivpm_vec_mem
  import ivpm_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire ivpm_pkg::ivpm_fetch_t vec_fetch,
  input  wire logic                  erased,
  input  wire logic [3:0]            lat,
  output var  logic [15:0]           vec_data,
  output var  logic                  vec_data_valid
);
  logic [3:0] cnt_q;
  // Answer lat+1 cycles after the request; data toggles whenever it is not valid
  always_ff @(posedge aclk) begin
    vec_data_valid <= 1'b0;
    vec_data <= ~vec_data;
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else if (vec_fetch.req && !vec_data_valid) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= lat) begin
        cnt_q <= 4'h0;
        vec_data_valid <= 1'b1;
        // Top region words hold handler addresses
        vec_data <= {8'hf9, vec_fetch.addr[7:0]};
        // Unprogrammed reset word reads all ones
        if (erased && vec_fetch.addr == VEC_RESET) vec_data <= 16'hffff;
      end
    end
  end
endmodule // ivpm_vec_mem
`default_nettype wire

// [ivpm_ctrl_test.sv]
// Self-checking bench for the vector and power mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ivpm_ctrl_test;
  import ivpm_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, erased = 1'b0, reti = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, re;
  logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] rst_events = 5'h00;
  logic [2:0] nmi_events = 3'h0;
  logic [N_MASK-1:0] mask_req = '0;
  logic [15:0] fetch_addr = 16'hf800, vec_data, pc_load_value, pe;
  logic fetch_valid = 1'b0, vec_data_valid, pc_load, sys_reset;
  ivpm_fetch_t vec_fetch;
  ivpm_clk_t clk_gate;
  int errors = 0, n_compared = 0, cyc = 0, a, b;
  logic [31:0] rng = 32'h3bb1e556;
  logic [31:0] exp_rd[$];
  logic [15:0] exp_pc[$];
  logic [15:0] vtab[5] = '{VEC_ITIMER, VEC_TCH0, VEC_TCH1, VEC_ADC,
                           VEC_SERIAL};
  logic [5:0] gtab[6] = '{6'h3f, 6'h0f, 6'h0f, 6'h07, 6'h05, 6'h00};

  ivpm_ctrl u_ivpm_ctrl (.*);
  ivpm_vec_mem u_ivpm_vec_mem (.aclk, .aresetn, .vec_fetch, .erased, .lat,
                               .vec_data, .vec_data_valid);

  // ---------------------------------------------------------------------
  // Clock, timeout and output watcher
  // ---------------------------------------------------------------------
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end
  // Oldest note is compared whenever a result shows up
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = exp_rd.size() ? exp_rd.pop_front() : 32'hxxxxxxxx;
      `CHK(s_axi_rdata, re)
    end
    if (pc_load && !erased) begin
      pe = exp_pc.size() ? exp_pc.pop_front() : 16'hxxxx;
      `CHK(pc_load_value, pe)
    end
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [15:0] vec_of(input int i);
    return (i < 5) ? vtab[i] : (i < 7) ? VEC_PORT_TWO : VEC_PORT_ONE;
  endfunction
  function automatic logic [15:0] hnd(input logic [15:0] v);
    return {8'hf9, v[7:0]};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  task automatic axr(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] r);
    exp_rd.push_back(d);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, r)
  endtask
  task automatic wait_pc();
    repeat (300) if (exp_pc.size()) @(posedge aclk);
    if (exp_pc.size()) `CHK(exp_pc.size(), 0)
    exp_pc.delete();
  endtask
  task automatic end_isr();
    @(posedge aclk);
    reti <= 1'b1;
    @(posedge aclk);
    reti <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic irq(input logic [14:0] m, input logic [15:0] v);
    exp_pc.push_back(hnd(v));
    @(posedge aclk);
    mask_req <= m;
    wait_pc();
    `CHK(clk_gate.cpu_run, 1'b1)
    mask_req <= '0;
    end_isr();
  endtask
  task automatic pulse(input logic nmi, input int k);
    @(posedge aclk);
    if (nmi) nmi_events[k] <= 1'b1;
    else rst_events[k] <= 1'b1;
    repeat (3) @(posedge aclk);
    nmi_events <= '0;
    rst_events <= '0;
    repeat (3) @(posedge aclk);
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    exp_pc.push_back(hnd(VEC_RESET));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wait_pc();
    axr(REG_RST_FLG, {27'h0, RST_FLG_RST}, 2'b00);
    axr(REG_MASK_EN, 32'h0, 2'b00);
    axr(REG_STATUS, {VEC_RESET, 16'h0004}, 2'b00);
    axw(8'h1c, 32'h1, 2'b10);
    axr(8'h20, 32'h0, 2'b10);
    axw(REG_MASK_EN, 32'h7fff, 2'b00);
    axw(REG_MODE, 32'h1, 2'b00);
    axr(REG_MODE, 32'h1, 2'b00);
    for (int i = 0; i < N_MASK; i++) irq(15'(1 << i), vec_of(i));
    repeat (8) begin
      rng = xs(rng);
      a = rng % 15;
      b = (rng >> 8) % 15;
      lat <= 4'(rng[17:16] + 1);
      irq(15'(1 << a) | 15'(1 << b),
          (vec_of(a) > vec_of(b)) ? vec_of(a) : vec_of(b));
    end
    // Wake from level three and return to it
    axw(REG_MODE, 32'h141, 2'b00);
    irq(15'h0080, VEC_PORT_ONE);
    `CHK(clk_gate, 6'h05)
    for (int s = 0; s < 6; s++) begin
      axw(REG_MODE, {23'h0, 1'b1, 1'b0, 3'(s), 4'h0}, 2'b00);
      repeat (3) @(posedge aclk);
      `CHK(clk_gate, gtab[s])
    end
    // Disabled NMI source must not wake level four
    pulse(1'b1, 0);
    `CHK(clk_gate, 6'h00)
    for (int k = 0; k < 3; k++) begin
      axw(REG_NMI_FLG, 32'h7, 2'b00);
      axw(REG_NMI_EN, 32'h7, 2'b00);
      exp_pc.push_back(hnd(VEC_NMI));
      pulse(1'b1, k);
      wait_pc();
      `CHK(clk_gate, 6'h3f)
      axr(REG_NMI_FLG, 32'(1 << k), 2'b00);
      axw(REG_NMI_FLG, 32'h7, 2'b00);
      end_isr();
      `CHK(clk_gate, 6'h00)
    end
    axw(REG_MODE, 32'h020, 2'b00);
    repeat (3) @(posedge aclk);
    `CHK(clk_gate, 6'h0d)
    for (int k = 0; k < 5; k++) begin
      axw(REG_RST_FLG, 32'h1f, 2'b00);
      exp_pc.push_back(hnd(VEC_RESET));
      pulse(1'b0, k);
      wait_pc();
      axr(REG_RST_FLG, 32'(1 << k), 2'b00);
    end
    for (int k = 0; k < 2; k++) begin
      exp_pc.push_back(hnd(VEC_RESET));
      @(posedge aclk);
      fetch_addr <= k ? 16'h3000 : 16'h0150;
      fetch_valid <= 1'b1;
      @(posedge aclk);
      fetch_valid <= 1'b0;
      wait_pc();
    end
    erased <= 1'b1;
    pulse(1'b0, 1);
    repeat (30) @(posedge aclk);
    `CHK(clk_gate, 6'h00)
    wrap_up();
  end
endmodule // ivpm_ctrl_test
`default_nettype wire
